/* File: pcd_pkg.sv */
/*
 * Shared constants, types and helpers for the third and fourth port pin
 * logic: register indices, reset values, function select codes and the
 * per-pin tables of legal functions.
 * Assumes a 32-bit APB slave where a register's byte address is its index
 * times four.
 */
`default_nettype none

package pcd_pkg;

    // ****************************************************************
    // Sizes and register map
    // ****************************************************************
    localparam int unsigned PCD_PINS  = 8;
    localparam int unsigned PCD_SEL_W = 3;
    localparam int unsigned PCD_ALT_N = 4;

    localparam logic [9:0] PCD_IDX_C_DATA = 10'h007;
    localparam logic [9:0] PCD_IDX_D_DATA = 10'h008;
    localparam logic [9:0] PCD_IDX_C_DIR  = 10'h087;
    localparam logic [9:0] PCD_IDX_D_DIR  = 10'h088;
    localparam logic [9:0] PCD_IDX_C_SEL  = 10'h090;
    localparam logic [9:0] PCD_IDX_D_SEL  = 10'h091;

    localparam logic [7:0]  PCD_DIR_RESET   = 8'hff;
    localparam logic [7:0]  PCD_LATCH_POR   = 8'h00;
    localparam logic [23:0] PCD_SEL_RESET   = 24'h000000;
    localparam logic [7:0]  PCD_OSC_PINS    = 8'hc0;
    localparam logic [7:0]  PCD_NONE        = 8'h00;
    localparam logic [7:0]  PCD_ALL         = 8'hff;

    // ****************************************************************
    // Function select codes and legal codes per pin (bit k = code k)
    // ****************************************************************
    localparam logic [2:0] PCD_SEL_GPIO = 3'h0;
    localparam logic [2:0] PCD_SEL_LCD  = 3'h1;
    localparam logic [2:0] PCD_SEL_ALT0 = 3'h2;

    // Pins 7..0 of the third port
    localparam logic [63:0] PCD_LEGAL_C = 64'h3f3f0f0f03010101;
    // Pins 7..0 of the fourth port
    localparam logic [63:0] PCD_LEGAL_D = 64'h0303030303050103;

    typedef enum logic [1:0] {
        PCD_OSC_LP  = 2'h0,
        PCD_OSC_XT  = 2'h1,
        PCD_OSC_HS  = 2'h2,
        PCD_OSC_INT = 2'h3
    } pcd_osc_t;

    typedef struct packed {
        logic [3:0] out;
        logic [3:0] drive_n;
    } pcd_alt_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] drive_n;
    } pcd_lcd_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe_n;
    } pcd_pins_t;

    localparam pcd_pins_t PCD_PINS_IDLE = 16'h00ff;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [7:0] pcd_osc_mask(input pcd_osc_t mode);
        pcd_osc_mask = (mode == PCD_OSC_INT) ? PCD_NONE : PCD_OSC_PINS;
    endfunction : pcd_osc_mask

    // Byte merge under the APB strobes, then drop unsupported codes to GPIO
    function automatic logic [23:0] pcd_sel_write(input logic [23:0] old,
                                                  input logic [23:0] wdata,
                                                  input logic [2:0]  strb,
                                                  input logic [63:0] legal);
        logic [23:0] merged;
        logic [2:0]  code;
        merged = old;
        for (int b = 0; b < 3; b++) begin
            if (strb[b]) begin
                merged[b*8 +: 8] = wdata[b*8 +: 8];
            end
        end
        for (int p = 0; p < PCD_PINS; p++) begin
            code = merged[p*PCD_SEL_W +: PCD_SEL_W];
            if (!legal[p*8 + int'(code)]) begin
                merged[p*PCD_SEL_W +: PCD_SEL_W] = PCD_SEL_GPIO;
            end
        end
        pcd_sel_write = merged;
    endfunction : pcd_sel_write

endpackage : pcd_pkg

`default_nettype wire

/* File: pcd_sync2.sv */
/*
 * Two flip-flop synchroniser for pin levels.
 * Assumes the inputs come from pins, asynchronous to pclk.
 */
`timescale 1ns/1ps
`default_nettype none

module pcd_sync2 #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : pcd_sync2

`default_nettype wire

/* File: pcd_port_mux.sv */
/*
 * Per-pin output selection for one eight-pin port: GPIO latch, LCD line or
 * one of four peripheral alternates, registered onto the pin drivers.
 * Assumes the select field only holds legal codes for each pin.
 */
`timescale 1ns/1ps
`default_nettype none

module pcd_port_mux
    import pcd_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic [7:0]            latch,
    input  wire logic [7:0]            dir,
    input  wire logic [23:0]           sel,
    input  wire logic [7:0]            hold,
    input  wire pcd_alt_t [7:0]        alt,
    input  wire pcd_lcd_t              lcd,
    output var  pcd_pins_t             pins
);

    pcd_pins_t pins_next;

    always_comb begin
        logic [2:0] code;
        logic [2:0] k;
        code = PCD_SEL_GPIO;
        k = 3'h0;
        pins_next = PCD_PINS_IDLE;
        for (int p = 0; p < PCD_PINS; p++) begin
            code = sel[p*PCD_SEL_W +: PCD_SEL_W];
            k = code - PCD_SEL_ALT0;
            if (hold[p]) begin
                pins_next.out[p]  = 1'b0;
                pins_next.oe_n[p] = 1'b1;
            end else begin
                case (code)
                    PCD_SEL_GPIO: begin
                        pins_next.out[p]  = latch[p];
                        pins_next.oe_n[p] = dir[p];
                    end
                    PCD_SEL_LCD: begin
                        pins_next.out[p]  = lcd.out[p];
                        pins_next.oe_n[p] = lcd.drive_n[p];
                    end
                    default: begin
                        pins_next.out[p]  = alt[p].out[k[1:0]];
                        pins_next.oe_n[p] = alt[p].drive_n[k[1:0]];
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins <= PCD_PINS_IDLE;
        end else begin
            pins <= pins_next;
        end
    end

endmodule : pcd_port_mux

`default_nettype wire

/* File: pcd_ports.sv */
/*
 * Third and fourth general purpose I/O ports: data latches, direction
 * registers, function selects and pin multiplexing, reached over APB.
 * Assumes pins arrive asynchronously, peripherals and the LCD driver run
 * on pclk, and sys_reset is a synchronous pulse from the reset controller
 * for every reset source other than power-on and brown-out.
 */
// Overview of operation
// - Fourth port: eight pins, filtered inputs
// - Each fourth port pin has own direction
// - Direction one tri-states, zero drives pin
// - Fourth direction at 88h, resets all ones
// - Fourth data read returns present pin levels
// - Oscillator modes force direction 7:6 read one
// - Data latches kept through non power resets
// - Third pin 3: GPIO or LCD segment
// - Third pin 4: GPIO, gate, serial out, LCD
// - Third pin 5: GPIO, timer clock, CCP, LCD
// - Third pin 6: GPIO, TX, clocks, I2C, LCD
// - Third pin 7: GPIO, RX, data lines, LCD
// - Fourth pin 0: GPIO or LCD common
// - Fourth pin 1: GPIO only
// - Fourth pin 2: GPIO or second CCP
// - Fourth pins 3-7: GPIO or LCD segments
// - LCD lines drive pins directly, own tri-state
// - Fourth port absent on small variants
// - Data write updates latch driven on outputs
// - Third direction at 87h, resets all ones
`timescale 1ns/1ps
`default_nettype none

module pcd_ports
    import pcd_pkg::*;
#(
    parameter bit HAS_FOURTH_PORT = 1'b1
) (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            sys_reset,
    input  wire pcd_osc_t        osc_mode,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [11:0]     paddr,
    input  wire logic [31:0]     pwdata,
    input  wire logic [3:0]      pstrb,
    output var  logic [31:0]     prdata,
    output var  logic            pready,
    output var  logic            pslverr,
    input  wire logic [7:0]      pin_c_in,
    input  wire logic [7:0]      pin_d_in,
    output var  pcd_pins_t       pins_c,
    output var  pcd_pins_t       pins_d,
    input  wire pcd_alt_t [7:0]  alt_c,
    input  wire pcd_alt_t [7:0]  alt_d,
    input  wire pcd_lcd_t        lcd_c,
    input  wire pcd_lcd_t        lcd_d,
    output var  logic [7:0]      level_c,
    output var  logic [7:0]      level_d,
    output var  logic [23:0]     sel_c,
    output var  logic [23:0]     sel_d
);

    // ****************************************************************
    // Pin inputs
    // ****************************************************************
    logic [7:0] lvl_c;
    logic [7:0] lvl_d;
    logic [7:0] pin_d_gated;

    // An absent port has no pads; keep its input path quiet
    assign pin_d_gated = HAS_FOURTH_PORT ? pin_d_in : PCD_NONE;

    // Pad buffers filter; here the levels are brought onto pclk
    pcd_sync2 #(
        .WIDTH    (PCD_PINS)
    ) u_sync_c (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (pin_c_in),
        .sync_out (lvl_c)
    );

    pcd_sync2 #(
        .WIDTH    (PCD_PINS)
    ) u_sync_d (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (pin_d_gated),
        .sync_out (lvl_d)
    );

    assign level_c = lvl_c;
    assign level_d = lvl_d;

    // ****************************************************************
    // APB decode
    // ****************************************************************
    logic        setup;
    logic        access;
    logic [9:0]  idx;
    logic        aligned;
    logic [7:0]  osc_mask;
    logic [31:0] rdata_next;
    logic        err_next;
    logic        wr_ok;
    logic        wr_c_data;
    logic        wr_d_data;
    logic        wr_c_dir;
    logic        wr_d_dir;
    logic        wr_c_sel;
    logic        wr_d_sel;
    logic [31:0] prdata_reg;
    logic        slverr_reg;
    logic [7:0]  latch_c_reg;
    logic [7:0]  latch_d_reg;
    logic [7:0]  dir_c_reg;
    logic [7:0]  dir_d_reg;
    logic [23:0] sel_c_reg;
    logic [23:0] sel_d_reg;

    assign setup    = psel & ~penable;
    assign access   = psel & penable;
    assign idx      = paddr[11:2];
    assign aligned  = (paddr[1:0] == 2'h0);
    assign osc_mask = pcd_osc_mask(osc_mode);

    always_comb begin
        rdata_next = '0;
        err_next   = 1'b0;
        if (!aligned) begin
            err_next = 1'b1;
        end else begin
            case (idx)
                PCD_IDX_C_DATA: begin
                    rdata_next[7:0] = lvl_c;
                end
                PCD_IDX_D_DATA: begin
                    rdata_next[7:0] = lvl_d;
                    err_next = !HAS_FOURTH_PORT;
                end
                PCD_IDX_C_DIR: begin
                    rdata_next[7:0] = dir_c_reg | osc_mask;
                end
                PCD_IDX_D_DIR: begin
                    rdata_next[7:0] = dir_d_reg | osc_mask;
                    err_next = !HAS_FOURTH_PORT;
                end
                PCD_IDX_C_SEL: begin
                    rdata_next[23:0] = sel_c_reg;
                end
                PCD_IDX_D_SEL: begin
                    rdata_next[23:0] = sel_d_reg;
                    err_next = !HAS_FOURTH_PORT;
                end
                default: begin
                    err_next = 1'b1;
                end
            endcase
        end
    end

    // Writes land only on the access edge and never on an error
    assign wr_ok     = access & pwrite & ~err_next;
    assign wr_c_data = wr_ok & pstrb[0] & (idx == PCD_IDX_C_DATA);
    assign wr_d_data = wr_ok & pstrb[0] & (idx == PCD_IDX_D_DATA);
    assign wr_c_dir  = wr_ok & pstrb[0] & (idx == PCD_IDX_C_DIR);
    assign wr_d_dir  = wr_ok & pstrb[0] & (idx == PCD_IDX_D_DIR);
    assign wr_c_sel  = wr_ok & (idx == PCD_IDX_C_SEL);
    assign wr_d_sel  = wr_ok & (idx == PCD_IDX_D_SEL);

    // Read data is caught in the setup cycle so the access phase is
    // zero wait; a pin change during the access phase shows next read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= '0;
            slverr_reg <= 1'b0;
        end else if (setup) begin
            prdata_reg <= rdata_next;
            slverr_reg <= err_next;
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = access;
    assign pslverr = access & slverr_reg;

    // ****************************************************************
    // Port registers
    // ****************************************************************
    // Only power-on reset touches the latches; other resets leave them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_c_reg <= PCD_LATCH_POR;
            latch_d_reg <= PCD_LATCH_POR;
        end else begin
            if (wr_c_data) begin
                latch_c_reg <= pwdata[7:0];
            end
            if (wr_d_data) begin
                latch_d_reg <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_c_reg <= PCD_DIR_RESET;
            dir_d_reg <= PCD_DIR_RESET;
        end else if (sys_reset) begin
            dir_c_reg <= PCD_DIR_RESET;
            dir_d_reg <= PCD_DIR_RESET;
        end else begin
            if (wr_c_dir) begin
                dir_c_reg <= pwdata[7:0];
            end
            if (wr_d_dir) begin
                dir_d_reg <= pwdata[7:0];
            end
        end
    end

    // Unsupported codes fall back to GPIO rather than a floating pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_c_reg <= PCD_SEL_RESET;
            sel_d_reg <= PCD_SEL_RESET;
        end else if (sys_reset) begin
            sel_c_reg <= PCD_SEL_RESET;
            sel_d_reg <= PCD_SEL_RESET;
        end else begin
            if (wr_c_sel) begin
                sel_c_reg <= pcd_sel_write(sel_c_reg, pwdata[23:0],
                                           pstrb[2:0], PCD_LEGAL_C);
            end
            if (wr_d_sel) begin
                sel_d_reg <= pcd_sel_write(sel_d_reg, pwdata[23:0],
                                           pstrb[2:0], PCD_LEGAL_D);
            end
        end
    end

    assign sel_c = sel_c_reg;
    assign sel_d = sel_d_reg;

    // ****************************************************************
    // Pin drivers
    // ****************************************************************
    logic [7:0] hold_d;

    assign hold_d = HAS_FOURTH_PORT ? osc_mask : PCD_ALL;

    pcd_port_mux u_mux_c (
        .pclk    (pclk),
        .presetn (presetn),
        .latch   (latch_c_reg),
        .dir     (dir_c_reg),
        .sel     (sel_c_reg),
        .hold    (osc_mask),
        .alt     (alt_c),
        .lcd     (lcd_c),
        .pins    (pins_c)
    );

    pcd_port_mux u_mux_d (
        .pclk    (pclk),
        .presetn (presetn),
        .latch   (latch_d_reg),
        .dir     (dir_d_reg),
        .sel     (sel_d_reg),
        .hold    (hold_d),
        .alt     (alt_d),
        .lcd     (lcd_d),
        .pins    (pins_d)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    dir_reset_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        sys_reset |=> (dir_c_reg == PCD_DIR_RESET)
                      && (dir_d_reg == PCD_DIR_RESET))
        else $error("direction not all ones after reset");

    latch_keep_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (sys_reset && !wr_c_data && !wr_d_data)
        |=> $stable(latch_c_reg) && $stable(latch_d_reg))
        else $error("data latch changed by a non power reset");

    pin_read_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (setup && aligned && idx == PCD_IDX_D_DATA && HAS_FOURTH_PORT)
        |=> (prdata[7:0] == $past(lvl_d)) && (pslverr == 1'b0))
        else $error("data read does not show pin levels");

    osc_readback_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (setup && aligned && idx == PCD_IDX_D_DIR
         && osc_mode != PCD_OSC_INT && HAS_FOURTH_PORT)
        |=> prdata[7:6] == 2'h3)
        else $error("direction 7:6 not read as one");

    latch_write_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_d_data |=> latch_d_reg == $past(pwdata[7:0]))
        else $error("data write not stored in latch");

    gpio_input_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (HAS_FOURTH_PORT && sel_d_reg[2:0] == PCD_SEL_GPIO && dir_d_reg[0])
        |=> pins_d.oe_n[0])
        else $error("input pin not tri-stated");

    gpio_drive_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (HAS_FOURTH_PORT && sel_d_reg[2:0] == PCD_SEL_GPIO && !dir_d_reg[0])
        |=> !pins_d.oe_n[0] && pins_d.out[0] == $past(latch_d_reg[0]))
        else $error("output pin not driving latch value");

    alt_override_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (sel_c_reg[17:15] == PCD_SEL_ALT0 + 3'h1 && !alt_c[5].drive_n[1])
        |=> !pins_c.oe_n[5] && pins_c.out[5] == $past(alt_c[5].out[1]))
        else $error("peripheral does not own its pin");

    lcd_direct_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        sel_c_reg[11:9] == PCD_SEL_LCD
        |=> pins_c.oe_n[3] == $past(lcd_c.drive_n[3])
            && pins_c.out[3] == $past(lcd_c.out[3]))
        else $error("segment line not passed to pin");

    gpio_only_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        sel_d_reg[5:3] == PCD_SEL_GPIO)
        else $error("pin with no alternate left GPIO");

    sel_legal_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_c_sel && pstrb[1] && pwdata[11:9] == PCD_SEL_ALT0)
        |=> sel_c_reg[11:9] == PCD_SEL_GPIO)
        else $error("unsupported function accepted");

    absent_port_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !HAS_FOURTH_PORT |-> pins_d.oe_n == PCD_ALL)
        else $error("absent port drives a pin");

endmodule : pcd_ports

`default_nettype wire

/* File: pcd_pin_model.sv */
/*
 * Board model for one eight-pin port: each pin the port releases is driven
 * by the board with a value chosen by the bench.
 * Assumes the pin bundle type from pcd_pkg.
 */
`timescale 1ns/1ps
`default_nettype none

module pcd_pin_model
    import pcd_pkg::*;
(
    input  wire pcd_pins_t  pins,
    input  wire logic [7:0] ext,
    output var  logic [7:0] level
);
    // Driven pins win; a released pin shows the board, never a stale value
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            level[i] = pins.oe_n[i] ? ext[i] : pins.out[i];
        end
    end
endmodule : pcd_pin_model

`default_nettype wire

/* File: tb.sv */
/*
 * Self-checking bench for the third and fourth port pin logic over APB.
 * Assumes the zero-wait APB slave and register timing of the port block.
 */
`timescale 1ns/1ps
`default_nettype none

module tb import pcd_pkg::*;;
    logic           pclk, presetn, sys_reset, psel, penable, pwrite, er;
    pcd_osc_t       osc_mode;
    logic [11:0]    paddr;
    logic [31:0]    pwdata, prdata, rd;
    logic           pready, pslverr;
    logic [7:0]     lvl_c, lvl_d, ext_c, ext_d, lat, dir, xl;
    logic [7:0]     lev_c, lev_d;
    logic [23:0]    sel_c, sel_d;
    pcd_pins_t      pins_c, pins_d;
    pcd_alt_t [7:0] alt_d;
    pcd_lcd_t       lcd_d;
    int             mismatches, samples_checked, seed, i;

    pcd_ports i_pcd_ports (.pclk(pclk), .presetn(presetn),
        .sys_reset(sys_reset), .osc_mode(osc_mode), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_c_in(lvl_c), .pin_d_in(lvl_d),
        .pins_c(pins_c), .pins_d(pins_d), .alt_c(alt_d), .alt_d(alt_d),
        .lcd_c(lcd_d), .lcd_d(lcd_d), .level_c(lev_c), .level_d(lev_d),
        .sel_c(sel_c), .sel_d(sel_d));
    // Both ports share one set of peripheral and segment lines
    pcd_pin_model i_pcd_pin_model (.pins(pins_c), .ext(ext_c),
        .level(lvl_c));
    pcd_pin_model i_pcd_pin_model_d (.pins(pins_d), .ext(ext_d),
        .level(lvl_d));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task print_verdict;
        if (mismatches == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    task chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    // Called just after a rising edge; idles one cycle after release
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 8; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 8) begin
            mismatches++;
            print_verdict;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    function automatic logic [7:0] pin_lvl(input logic [7:0] l, d, x);
        return (d & x) | (~d & l);
    endfunction : pin_lvl

    initial begin
        seed = 32'h526a9351;
        {presetn, sys_reset, psel, penable, pwrite} = 5'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        osc_mode = PCD_OSC_INT;
        ext_c = 8'h5a;
        ext_d = 8'ha5;
        alt_d = '1;
        lcd_d = '1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h21c, 0);
        chk(rd, 32'hff);
        apb(1'b0, 12'h220, 0);
        chk(rd, 32'hff);
        // ****************************************************
        // Random latch, direction and board values, both ports
        // ****************************************************
        for (i = 0; i < 40; i++) begin
            lat = $random(seed);
            dir = (i < 2) ? {8{i[0]}} : 8'($random(seed));
            ext_c <= $random(seed);
            ext_d <= $random(seed);
            apb(1'b1, i[0] ? 12'h01c : 12'h020, lat);
            apb(1'b1, i[0] ? 12'h21c : 12'h220, dir);
            repeat (4) @(posedge pclk);
            apb(1'b0, i[0] ? 12'h01c : 12'h020, 0);
            xl = pin_lvl(lat, dir, i[0] ? ext_c : ext_d);
            chk(rd, xl);
            chk(i[0] ? pins_c.oe_n : pins_d.oe_n, dir);
            chk(i[0] ? lev_c : lev_d, xl);
        end
        apb(1'b1, 12'h220, 0);
        for (i = 0; i < 3; i++) begin
            osc_mode <= pcd_osc_t'(i);
            apb(1'b0, 12'h220, 0);
            chk(rd, 32'hc0);
        end
        osc_mode <= PCD_OSC_INT;
        apb(1'b1, 12'h020, 32'h3c);
        sys_reset <= 1'b1;
        @(posedge pclk);
        sys_reset <= 1'b0;
        apb(1'b0, 12'h220, 0);
        chk(rd, 32'hff);
        apb(1'b1, 12'h220, 0);
        repeat (4) @(posedge pclk);
        apb(1'b0, 12'h020, 0);
        chk(rd, 32'h3c);
        // Pin 1 refuses its code; pins 0 and 3 LCD, pin 2 alternate
        apb(1'b1, 12'h244, 32'h291);
        apb(1'b0, 12'h244, 0);
        chk(rd, 32'h281);
        chk(sel_d, 24'h000281);
        alt_d[2].drive_n[0] <= 1'b0;
        alt_d[2].out[0] <= 1'b0;
        lcd_d <= 16'h0108;
        repeat (3) @(posedge pclk);
        chk(pins_d.oe_n[3:0], 4'h8);
        chk(pins_d.out[2:0], 3'h1);
        alt_d[2].drive_n[0] <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(pins_d.oe_n[2], 1'b1);
        // Third port: pin 3 refuses an alternate, pin 5 takes one
        apb(1'b1, 12'h240, 32'h18400);
        chk(sel_c, 24'h018000);
        alt_d[5].drive_n[1] <= 1'b0;
        alt_d[5].out[1] <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({pins_c.oe_n[5], pins_c.out[5]}, 2'h1);
        lcd_d <= 16'h0800;
        apb(1'b1, 12'h240, 32'h18200);
        repeat (2) @(posedge pclk);
        chk({pins_c.oe_n[3], pins_c.out[3]}, 2'h1);
        apb(1'b0, 12'h3fc, 0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        print_verdict;
    end
endmodule : tb

`default_nettype wire
